//--- core/fps_cpu.sv
// cpu end: issues register instructions and the guarded launch sequence
// assumes the device end sits on the same clock and link interface
`timescale 1ns/100ps
module fps_cpu
    import fps_pkg::*;
(
    input  wire logic              SYS_CLK_IN,
    input  wire logic              RST_B_IN,
    fps_link_if.cpu                link,
    input  wire logic              CMD_VALID_IN,
    input  wire logic [2:0]        CMD_CODE_IN,
    input  wire logic [DATA_W-1:0] CMD_DATA_IN,
    output logic                   CMD_READY_OUT,
    output logic                   DONE_OUT,
    output logic [DATA_W-1:0]      RDATA_OUT,
    output logic                   IRQ_MASK_OUT
);
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ONE,
        ST_KEY2,
        ST_GAP,
        ST_POLL
    } fps_cpu_state_t;

    fps_cpu_state_t     state_q;
    logic               instr_q;
    logic               ctl_wr_q;
    logic               sta_wr_q;
    logic               load_q;
    logic [DATA_W-1:0]  wdata_q;
    logic [DATA_W-1:0]  cfg_q;
    logic               rd_ctl_q;
    logic               rd_sta_q;
    logic               done_q;
    logic [DATA_W-1:0]  rdata_q;
    logic               irq_mask_q;
    fps_cmd_t           cmd;

    assign cmd = fps_cmd_t'(CMD_CODE_IN);

    always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
        begin
            state_q    <= ST_IDLE;
            instr_q    <= 1'b0;
            ctl_wr_q   <= 1'b0;
            sta_wr_q   <= 1'b0;
            load_q     <= 1'b0;
            wdata_q    <= CTL_RESET;
            cfg_q      <= CTL_RESET;
            rd_ctl_q   <= 1'b0;
            rd_sta_q   <= 1'b0;
            done_q     <= 1'b0;
            rdata_q    <= CTL_RESET;
            irq_mask_q <= 1'b0;
        end
        else
        begin
            instr_q  <= 1'b0;
            ctl_wr_q <= 1'b0;
            sta_wr_q <= 1'b0;
            load_q   <= 1'b0;
            rd_ctl_q <= 1'b0;
            rd_sta_q <= 1'b0;
            done_q   <= 1'b0;
            case (state_q)
                ST_IDLE:
                begin
                    if (CMD_VALID_IN)
                    begin
                        instr_q <= 1'b1;
                        wdata_q <= CMD_DATA_IN;
                        state_q <= ST_ONE;
                        case (cmd)
                            CMD_WR_CTL: ctl_wr_q <= 1'b1;
                            CMD_WR_STA: sta_wr_q <= 1'b1;
                            CMD_LOAD:   load_q   <= 1'b1;
                            CMD_RD_CTL: rd_ctl_q <= 1'b1;
                            CMD_RD_STA: rd_sta_q <= 1'b1;
                            CMD_LAUNCH:
                            begin
                                irq_mask_q <= 1'b1;
                                ctl_wr_q   <= 1'b1;
                                cfg_q      <= CMD_DATA_IN;
                                wdata_q    <= {KEY_FIRST,
                                               CMD_DATA_IN[CTL_KEY_LO-1:0]};
                                state_q    <= ST_KEY2;
                            end
                            default:    instr_q  <= 1'b1;
                        endcase
                    end
                end
                ST_ONE:
                begin
                    done_q  <= 1'b1;
                    rdata_q <= rd_ctl_q ? link.ctl_rdata :
                               (rd_sta_q ? link.sta_rdata : rdata_q);
                    state_q <= ST_IDLE;
                end
                ST_KEY2:
                begin
                    instr_q  <= 1'b1;
                    ctl_wr_q <= 1'b1;
                    wdata_q  <= {KEY_SECOND, cfg_q[CTL_KEY_LO-1:0]};
                    state_q  <= ST_GAP;
                end
                ST_GAP:
                begin
                    instr_q <= 1'b1;
                    state_q <= ST_POLL;
                end
                ST_POLL:
                begin
                    instr_q  <= 1'b1;
                    rd_ctl_q <= 1'b1;
                    // one instruction per poll keeps the read timing plain
                    // first read is second instruction after A key
                    if (rd_ctl_q && !link.ctl_rdata[CTL_BUSY_BIT])
                    begin
                        instr_q    <= 1'b0;
                        rd_ctl_q   <= 1'b0;
                        done_q     <= 1'b1;
                        rdata_q    <= link.sta_rdata;
                        irq_mask_q <= 1'b0;
                        state_q    <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    assign link.instr_stb      = instr_q;
    assign link.ctl_wr_stb     = ctl_wr_q;
    assign link.sta_wr_stb     = sta_wr_q;
    assign link.latch_load_stb = load_q;
    assign link.wdata          = wdata_q;
    assign CMD_READY_OUT       = (state_q == ST_IDLE);
    assign DONE_OUT            = done_q;
    assign RDATA_OUT           = rdata_q;
    assign IRQ_MASK_OUT        = irq_mask_q;
endmodule

//--- core/fps_device.sv
// flash program launch sequencer: control/status registers and unlock check
// assumes the cpu marks every instruction with instr_stb, writes included,
// and that the flash engine pulses PROG_DONE_IN once per started operation
`timescale 1ns/100ps

// Functional notes
// - space 10: A key programs fuse bits
// - space 11: A key clears column latches
// - A key must directly follow 5 key
// - both keys carry the same space select
// - cpu keeps interrupts off while programming started by its launch command
// - busy flag shows programming in progress
// - busy rises second cycle after sequence
// - busy clears when programming finishes
// - bad sequence sets error; good one clears
// - space 00 user, 01 extra row writes
// - loaded flag on first latch byte
module fps_device
    import fps_pkg::*;
(
    input  wire logic       SYS_CLK_IN,
    input  wire logic       RST_B_IN,
    fps_link_if.dev         link,
    input  wire logic       PROG_DONE_IN,
    output logic            PROG_START_OUT,
    output logic [1:0]      PROG_SPACE_OUT,
    output logic            LATCH_CLEAR_OUT,
    output logic            LATCH_MAP_OUT,
    output logic            BUSY_OUT
);
    logic [3:0] key_q;
    logic       map_q;
    logic [1:0] sp_q;
    logic       busy_q;
    logic       armed_q;
    logic [1:0] armed_sp_q;
    logic       launch_q;
    logic [1:0] launch_sp_q;
    logic       start_q;
    logic [1:0] prog_sp_q;
    logic       clear_q;
    logic       loaded_q;
    logic       sequence_error_flag_q;

    logic [3:0] wr_key;
    logic [1:0] wr_sp;
    logic       first_key;
    logic       second_key;
    logic       space_ok;
    logic       data_ok;
    logic       seq_ok;
    logic       seq_bad;
    logic       broken;

    assign wr_key     = link.wdata[CTL_KEY_HI:CTL_KEY_LO];
    assign wr_sp      = link.wdata[CTL_SP_HI:CTL_SP_LO];
    assign first_key  = link.ctl_wr_stb && (wr_key == KEY_FIRST);
    assign second_key = link.ctl_wr_stb && (wr_key == KEY_SECOND) && armed_q;
    assign space_ok   = (wr_sp == armed_sp_q);
    // latch reset needs no loaded data; every other space does
    assign data_ok    = (wr_sp == SP_LATCH_RST) || loaded_q;
    // a new launch while busy would corrupt the running operation
    assign seq_ok     = second_key && space_ok && data_ok && !busy_q;
    assign broken     = armed_q && link.instr_stb && !second_key;
    assign seq_bad    = broken || (second_key && !seq_ok);

    // control register fields; busy bit is not writable
    always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
        begin
            key_q <= CTL_RESET[CTL_KEY_HI:CTL_KEY_LO];
            map_q <= CTL_RESET[CTL_MAP_BIT];
            sp_q  <= CTL_RESET[CTL_SP_HI:CTL_SP_LO];
        end
        else if (link.ctl_wr_stb)
        begin
            key_q <= wr_key;
            map_q <= link.wdata[CTL_MAP_BIT];
            sp_q  <= wr_sp;
        end
    end

    // unlock tracking: armed only for the instruction right after the 5 key
    always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
        begin
            armed_q    <= 1'b0;
            armed_sp_q <= SP_USER;
        end
        else if (first_key)
        begin
            armed_q    <= 1'b1;
            armed_sp_q <= wr_sp;
        end
        else if (link.instr_stb || link.ctl_wr_stb)
        begin
            armed_q    <= 1'b0;
        end
    end

    // launch stage: first machine cycle after the A key
    always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
        begin
            launch_q    <= 1'b0;
            launch_sp_q <= SP_USER;
        end
        else
        begin
            launch_q    <= seq_ok;
            if (seq_ok)
            begin
                launch_sp_q <= wr_sp;
            end
        end
    end

    // busy and start: second machine cycle after the A key
    always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
        begin
            busy_q    <= 1'b0;
            start_q   <= 1'b0;
            prog_sp_q <= SP_USER;
        end
        else
        begin
            start_q <= 1'b0;
            if (launch_q && (launch_sp_q != SP_LATCH_RST))
            begin
                busy_q    <= 1'b1;
                start_q   <= 1'b1;
                prog_sp_q <= launch_sp_q;
            end
            else if (PROG_DONE_IN && busy_q)
            begin
                busy_q <= 1'b0;
            end
        end
    end

    // latch clear: manual reset sequence, or automatic after a write
    always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
        begin
            clear_q <= 1'b0;
        end
        else
        begin
            clear_q <= (launch_q && (launch_sp_q == SP_LATCH_RST))
                       || (PROG_DONE_IN && busy_q);
        end
    end

    // latches loaded flag; loads during busy are ignored by the latches
    always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
        begin
            loaded_q <= STA_RESET[STA_LOADED];
        end
        else if (link.latch_load_stb && !busy_q)
        begin
            loaded_q <= 1'b1;
        end
        else if (seq_ok)
        begin
            loaded_q <= 1'b0;
        end
    end

    // sequence error flag; a hardware set beats a software clear
    always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
        begin
            sequence_error_flag_q <= STA_RESET[STA_SEQUENCE_ERROR_FLAG];
        end
        else if (seq_bad)
        begin
            sequence_error_flag_q <= 1'b1;
        end
        else if (seq_ok)
        begin
            sequence_error_flag_q <= 1'b0;
        end
        else if (link.sta_wr_stb && !link.wdata[STA_SEQUENCE_ERROR_FLAG])
        begin
            sequence_error_flag_q <= 1'b0;
        end
    end

    always_comb
    begin
        link.ctl_rdata               = CTL_RESET;
        link.ctl_rdata[CTL_KEY_HI:CTL_KEY_LO] = key_q;
        link.ctl_rdata[CTL_MAP_BIT]  = map_q;
        link.ctl_rdata[CTL_SP_HI:CTL_SP_LO] = sp_q;
        link.ctl_rdata[CTL_BUSY_BIT] = busy_q;
        link.sta_rdata               = STA_RESET;
        link.sta_rdata[STA_SEQUENCE_ERROR_FLAG]   = sequence_error_flag_q;
        link.sta_rdata[STA_LOADED]   = loaded_q;
    end

    assign PROG_START_OUT  = start_q;
    assign PROG_SPACE_OUT  = prog_sp_q;
    assign LATCH_CLEAR_OUT = clear_q;
    assign LATCH_MAP_OUT   = map_q;
    assign BUSY_OUT        = busy_q;
endmodule

//--- core/fps_link_if.sv
// cpu to flash sequencer register link, one instruction per clock
// assumes both ends share SYS_CLK_IN; no crossing needed
`timescale 1ns/100ps
interface fps_link_if;
    import fps_pkg::*;
    logic              instr_stb;
    logic              ctl_wr_stb;
    logic              sta_wr_stb;
    logic              latch_load_stb;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] ctl_rdata;
    logic [DATA_W-1:0] sta_rdata;

    modport dev
    (
        input  instr_stb,
        input  ctl_wr_stb,
        input  sta_wr_stb,
        input  latch_load_stb,
        input  wdata,
        output ctl_rdata,
        output sta_rdata
    );

    modport cpu
    (
        output instr_stb,
        output ctl_wr_stb,
        output sta_wr_stb,
        output latch_load_stb,
        output wdata,
        input  ctl_rdata,
        input  sta_rdata
    );
endinterface

//--- core/fps_pkg.sv
// shared constants for the flash program launch sequencer and its cpu end
// assumes one machine cycle per clock on both ends
package fps_pkg;
    localparam int          DATA_W        = 8;
    // flash control register fields
    localparam int          CTL_KEY_HI    = 7;
    localparam int          CTL_KEY_LO    = 4;
    localparam int          CTL_MAP_BIT   = 3;
    localparam int          CTL_SP_HI     = 2;
    localparam int          CTL_SP_LO     = 1;
    localparam int          CTL_BUSY_BIT  = 0;
    // flash status register fields
    localparam int          STA_SEQUENCE_ERROR_FLAG    = 1;
    localparam int          STA_LOADED    = 0;
    localparam logic [7:0]  CTL_RESET     = 8'h00;
    localparam logic [7:0]  STA_RESET     = 8'h00;
    // unlock key nibbles
    localparam logic [3:0]  KEY_FIRST     = 4'h5;
    localparam logic [3:0]  KEY_SECOND    = 4'hA;
    localparam logic [3:0]  KEY_NONE      = 4'h0;
    // memory space selects
    localparam logic [1:0]  SP_USER       = 2'h0;
    localparam logic [1:0]  SP_EXTRA_ROW  = 2'h1;
    localparam logic [1:0]  SP_SECURITY   = 2'h2;
    localparam logic [1:0]  SP_LATCH_RST  = 2'h3;
    // cpu end command codes
    typedef enum logic [2:0] {
        CMD_NOP       = 3'h0,
        CMD_WR_CTL    = 3'h1,
        CMD_RD_CTL    = 3'h2,
        CMD_WR_STA    = 3'h3,
        CMD_RD_STA    = 3'h4,
        CMD_LOAD      = 3'h5,
        CMD_LAUNCH    = 3'h6
    } fps_cmd_t;
endpackage

//--- test/flash_program_launch_sequencer_test.sv
// bench: cpu end and device end joined by the link interface
// assumes the flash engine is played here by a done responder
`timescale 1ns/100ps
module flash_program_launch_sequencer_test
    import fps_pkg::*;
;
    logic        sys_clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        cmd_valid = 1'b0;
    logic [2:0]  cmd_code = 3'h0;
    logic [7:0]  cmd_data = 8'h00;
    logic        prog_done = 1'b0;
    logic        cmd_ready, done_out, prog_start, latch_clear, busy, irq_mask;
    logic [7:0]  rdata;
    logic [1:0]  prog_space;
    logic [1:0]  exp_sp = 2'h0;
    logic [8:0]  exp_q[$];
    logic [31:0] rng_q = 32'h0001_6570;
    int          failures = 0;
    int          n_checks = 0;

    fps_link_if link();
    fps_device i_fps_device(.SYS_CLK_IN(sys_clk), .RST_B_IN(rst_b),
        .link(link.dev), .PROG_DONE_IN(prog_done),
        .PROG_START_OUT(prog_start), .PROG_SPACE_OUT(prog_space),
        .LATCH_CLEAR_OUT(latch_clear), .LATCH_MAP_OUT(), .BUSY_OUT(busy));
    fps_cpu i_fps_cpu(.SYS_CLK_IN(sys_clk), .RST_B_IN(rst_b),
        .link(link.cpu), .CMD_VALID_IN(cmd_valid), .CMD_CODE_IN(cmd_code),
        .CMD_DATA_IN(cmd_data), .CMD_READY_OUT(cmd_ready),
        .DONE_OUT(done_out), .RDATA_OUT(rdata), .IRQ_MASK_OUT(irq_mask));
    fps_assertions i_fps_assertions(.SYS_CLK_IN(sys_clk), .RST_B_IN(rst_b),
        .instr_stb(link.instr_stb), .ctl_wr_stb(link.ctl_wr_stb),
        .latch_load_stb(link.latch_load_stb), .wdata(link.wdata),
        .ctl_rdata(link.ctl_rdata), .sta_rdata(link.sta_rdata),
        .PROG_DONE_IN(prog_done), .PROG_START_OUT(prog_start),
        .PROG_SPACE_OUT(prog_space), .LATCH_CLEAR_OUT(latch_clear),
        .BUSY_OUT(busy), .IRQ_MASK_OUT(irq_mask));

    always #20 sys_clk = ~sys_clk;

    function logic [7:0] rnd();
        rng_q = rng_q ^ (rng_q << 13);
        rng_q = rng_q ^ (rng_q >> 17);
        rng_q = rng_q ^ (rng_q << 5);
        return rng_q[7:0];
    endfunction

    task wrap_up();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // chk low: a write or nop, whose done carries no fresh read data
    task cmd(input logic [2:0] c, input logic [7:0] d, input logic chk,
             input logic [7:0] e);
        @(posedge sys_clk);
        exp_q.push_back({chk, e});
        cmd_valid <= 1'b1;
        cmd_code <= c;
        cmd_data <= d;
        do @(posedge sys_clk); while (cmd_ready !== 1'b1);
        cmd_valid <= 1'b0;
    endtask

    initial
    begin
        repeat (20) @(posedge sys_clk);
        rst_b <= 1'b1;
        cmd(CMD_RD_CTL, 8'h00, 1'b1, CTL_RESET);
        cmd(CMD_RD_STA, 8'h00, 1'b1, STA_RESET);
        cmd(CMD_WR_CTL, 8'hFF, 1'b0, 8'h00);
        cmd(CMD_RD_CTL, 8'h00, 1'b1, 8'hFE);
        cmd(CMD_WR_CTL, 8'h00, 1'b0, 8'h00);
        cmd(CMD_LAUNCH, 8'h00, 1'b1, 8'h02);
        // every space, first one also clears the error
        for (int s = 0; s < 4; s++)
        begin
            cmd(CMD_LOAD, rnd(), 1'b0, 8'h00);
            cmd(CMD_RD_STA, 8'h00, 1'b1, {6'h00, s == 0, 1'b1});
            exp_sp = s[1:0];
            cmd(CMD_LAUNCH, {5'h00, s[1:0], 1'b0}, 1'b1, 8'h00);
        end
        // space change between keys is refused
        cmd(CMD_LOAD, rnd(), 1'b0, 8'h00);
        cmd(CMD_WR_CTL, 8'h50, 1'b0, 8'h00);
        cmd(CMD_WR_CTL, 8'hA2, 1'b0, 8'h00);
        cmd(CMD_RD_STA, 8'h00, 1'b1, 8'h03);
        cmd(CMD_WR_STA, 8'h00, 1'b0, 8'h00);
        // an instruction between the keys breaks them
        cmd(CMD_WR_CTL, 8'h56, 1'b0, 8'h00);
        cmd(CMD_NOP, rnd(), 1'b0, 8'h00);
        cmd(CMD_RD_STA, 8'h00, 1'b1, 8'h03);
        cmd(CMD_LAUNCH, 8'h06, 1'b1, 8'h00);
        // software clear of the error flag
        cmd(CMD_LAUNCH, 8'h02, 1'b1, 8'h02);
        cmd(CMD_WR_STA, rnd() & 8'hFD, 1'b0, 8'h00);
        cmd(CMD_RD_STA, 8'h00, 1'b1, 8'h00);
        for (int i = 0; i < 200 && exp_q.size() > 0; i++)
            @(posedge sys_clk);
        if (exp_q.size() != 0)
            failures++;
        wrap_up();
    end

    // flash engine: random busy time keeps the poll loop honest
    initial forever
    begin
        @(posedge sys_clk);
        if (prog_start === 1'b1)
        begin
            check({6'h00, prog_space}, {6'h00, exp_sp});
            repeat (1 + (rnd() & 8'h07)) @(posedge sys_clk);
            prog_done <= 1'b1;
            @(posedge sys_clk);
            prog_done <= 1'b0;
        end
    end

    initial forever
    begin
        logic [8:0] e;
        @(posedge sys_clk);
        if (done_out === 1'b1)
        begin
            if (exp_q.size() == 0)
                failures++;
            else
            begin
                e = exp_q.pop_front();
                if (e[8])
                    check(rdata, e[7:0]);
            end
        end
    end

    initial
    begin
        repeat (20000) @(posedge sys_clk);
        failures++;
        wrap_up();
    end
endmodule

//--- test/fps_assertions.sv
// checker for the launch sequencer link and device outputs
// assumes it sits beside the link interface, with plain signal inputs
`timescale 1ns/100ps
module fps_assertions
    import fps_pkg::*;
(
    input wire logic              SYS_CLK_IN,
    input wire logic              RST_B_IN,
    input wire logic              instr_stb,
    input wire logic              ctl_wr_stb,
    input wire logic              latch_load_stb,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic [DATA_W-1:0] ctl_rdata,
    input wire logic [DATA_W-1:0] sta_rdata,
    input wire logic              PROG_DONE_IN,
    input wire logic              PROG_START_OUT,
    input wire logic [1:0]        PROG_SPACE_OUT,
    input wire logic              LATCH_CLEAR_OUT,
    input wire logic              BUSY_OUT,
    input wire logic              IRQ_MASK_OUT
);
    logic       arm_q;
    logic [1:0] sp_q;
    logic       seq_ok;

    // first key seen with no instruction since, with its space
    always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
        begin
            arm_q <= 1'b0;
            sp_q  <= 2'h0;
        end
        else if (ctl_wr_stb && wdata[CTL_KEY_HI:CTL_KEY_LO] == KEY_FIRST)
        begin
            arm_q <= 1'b1;
            sp_q  <= wdata[CTL_SP_HI:CTL_SP_LO];
        end
        else if (instr_stb || ctl_wr_stb)
        begin
            arm_q <= 1'b0;
        end
    end

    // idle cycles keep the pair armed; any instruction ends it
    assign seq_ok = ctl_wr_stb && arm_q && !ctl_rdata[CTL_BUSY_BIT]
        && wdata[CTL_KEY_HI:CTL_KEY_LO] == KEY_SECOND
        && wdata[CTL_SP_HI:CTL_SP_LO] == sp_q
        && (sp_q == SP_LATCH_RST || sta_rdata[STA_LOADED]);

    default clocking @(posedge SYS_CLK_IN); endclocking
    default disable iff (!RST_B_IN);

    prog_launch_a:
        assert property (seq_ok && sp_q != SP_LATCH_RST |-> ##2 PROG_START_OUT
            && BUSY_OUT && PROG_SPACE_OUT == $past(sp_q, 2))
        else $error("launch not seen");
    latch_reset_a:
        assert property (seq_ok && sp_q == SP_LATCH_RST |-> ##2
            LATCH_CLEAR_OUT && !BUSY_OUT) else $error("latch reset missing");
    start_cause_a:
        assert property (PROG_START_OUT |-> $past(seq_ok, 2))
        else $error("start without sequence");
    sequence_error_flag_set_a:
        assert property (arm_q && instr_stb && !seq_ok |=>
            sta_rdata[STA_SEQUENCE_ERROR_FLAG]) else $error("error flag not set");
    flags_clear_a:
        assert property (seq_ok |=> !sta_rdata[STA_SEQUENCE_ERROR_FLAG]
            && !sta_rdata[STA_LOADED]) else $error("flags not cleared");
    busy_done_a:
        assert property (BUSY_OUT && PROG_DONE_IN |=> !BUSY_OUT
            && !ctl_rdata[CTL_BUSY_BIT] && LATCH_CLEAR_OUT)
        else $error("busy not cleared");
    busy_write_a:
        assert property (ctl_wr_stb && !PROG_DONE_IN && !$past(seq_ok) |=>
            $stable(ctl_rdata[CTL_BUSY_BIT])) else $error("busy written");
    load_flag_a:
        assert property (latch_load_stb && !ctl_rdata[CTL_BUSY_BIT] |=>
            sta_rdata[STA_LOADED]) else $error("loaded flag not set");
    irq_mask_a:
        assert property (BUSY_OUT |-> IRQ_MASK_OUT)
        else $error("interrupts open while busy");

    cover property (seq_ok && sp_q != SP_LATCH_RST);
    cover property (seq_ok && sp_q == SP_LATCH_RST);
    cover property (arm_q && instr_stb && !seq_ok);
endmodule
